//--- smsd_pkg.sv
package smsd_pkg;

	// status vectors reported by the controller
	localparam logic [3:0] ST_START = 4'hE;
	localparam logic [3:0] ST_TX = 4'hC;
	localparam logic [3:0] ST_RX = 4'h8;

	// response actions written by software
	localparam int ACT_W = 5;
	localparam logic [ACT_W-1:0] ACT_BEGIN = 5'h00;
	localparam logic [ACT_W-1:0] ACT_LOAD_ADDR = 5'h01;
	localparam logic [ACT_W-1:0] ACT_RESTART = 5'h02;
	localparam logic [ACT_W-1:0] ACT_ABORT = 5'h03;
	localparam logic [ACT_W-1:0] ACT_LOAD_DATA = 5'h04;
	localparam logic [ACT_W-1:0] ACT_STOP = 5'h05;
	localparam logic [ACT_W-1:0] ACT_STOP_START = 5'h06;
	localparam logic [ACT_W-1:0] ACT_REP_START = 5'h07;
	localparam logic [ACT_W-1:0] ACT_TO_RX = 5'h08;
	localparam logic [ACT_W-1:0] ACT_RX_ACK = 5'h09;
	localparam logic [ACT_W-1:0] ACT_RX_NACK_STOP = 5'h0A;
	localparam logic [ACT_W-1:0] ACT_RX_NACK_STOP_START = 5'h0B;
	localparam logic [ACT_W-1:0] ACT_RX_ACK_REP = 5'h0C;
	localparam logic [ACT_W-1:0] ACT_RX_NACK_REP = 5'h0D;
	localparam logic [ACT_W-1:0] ACT_RX_ACK_TX = 5'h0E;
	localparam logic [ACT_W-1:0] ACT_RX_NACK_TX = 5'h0F;

	// register map
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_CMD = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h0C;

	// command register fields
	localparam int CMD_ACT_LSB = 0;
	localparam int CMD_DATA_LSB = 8;
	localparam int BYTE_W = 8;

	// status register fields
	localparam int STS_VEC_LSB = 0;
	localparam int STS_ARB_BIT = 4;
	localparam int STS_ACK_BIT = 5;
	localparam int STS_SI_BIT = 6;
	localparam int STS_BUSY_BIT = 7;
	localparam int STS_EXP_LSB = 8;
	localparam int STS_EXPV_BIT = 12;
	localparam int STS_RX_LSB = 16;

	// interrupt bits
	localparam int IRQ_W = 3;
	localparam int IRQ_BYTE = 0;
	localparam int IRQ_ILLEGAL = 1;
	localparam int IRQ_UNEXP = 2;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

	// bus constants
	localparam int HTRANS_ACT_BIT = 1;
	localparam logic HRESP_OKAY = 1'b0;
	localparam int SYNC_STAGES = 2;

endpackage

//--- smsd_sync.sv
`timescale 1ns/1ps
module smsd_sync
	import smsd_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// asynchronous in, synchronous out
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stageQ [SYNC_STAGES];

	// first stage feeds only the second
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stageQ[0] <= '0;
			stageQ[1] <= '0;
		end else begin
			stageQ[0] <= asyncIn;
			stageQ[1] <= stageQ[0];
		end
	end

	assign syncOut = stageQ[1];

endmodule

//--- smsd_decode.sv
`timescale 1ns/1ps
module smsd_decode
	import smsd_pkg::*;
(
	// latched controller state
	input wire logic [3:0] statusVec,
	input wire logic arbitration_lost_flag,
	input wire logic ackBit,
	input wire logic pending,
	// requested response
	input wire logic [ACT_W-1:0] action,
	// decoded response
	output logic legal,
	output logic beginVal,
	output logic haltVal,
	output logic ackVal,
	output logic loadData,
	output logic [3:0] expNext,
	output logic expValid
);

	logic txAck;
	logic txNack;
	logic rxReq;
	logic rowOk;

	// which table row the controller stands in
	assign txAck = pending && !arbitration_lost_flag && statusVec == ST_TX && ackBit;
	assign txNack = pending && !arbitration_lost_flag && statusVec == ST_TX && !ackBit;
	assign rxReq = pending && !arbitration_lost_flag && statusVec == ST_RX;
	assign legal = rowOk;

	// response values per action; transmit rows drive ack low as don't-care
	always_comb begin
		rowOk = 1'b0;
		beginVal = 1'b0;
		haltVal = 1'b0;
		ackVal = 1'b0;
		loadData = 1'b0;
		expNext = ST_START;
		expValid = 1'b0;
		case (action)
			ACT_BEGIN: begin
				rowOk = !pending;
				beginVal = 1'b1;
				expValid = 1'b1;
			end
			ACT_LOAD_ADDR: begin
				rowOk = pending && !arbitration_lost_flag && statusVec == ST_START;
				loadData = 1'b1;
				expNext = ST_TX;
				expValid = 1'b1;
			end
			ACT_RESTART: begin
				rowOk = txNack;
				beginVal = 1'b1;
				expValid = 1'b1;
			end
			ACT_ABORT: begin
				rowOk = txNack;
				haltVal = 1'b1;
			end
			ACT_LOAD_DATA: begin
				rowOk = txAck;
				loadData = 1'b1;
				expNext = ST_TX;
				expValid = 1'b1;
			end
			ACT_STOP: begin
				rowOk = txAck;
				haltVal = 1'b1;
			end
			ACT_STOP_START: begin
				rowOk = txAck;
				beginVal = 1'b1;
				haltVal = 1'b1;
			end
			ACT_REP_START: begin
				rowOk = txAck;
				beginVal = 1'b1;
				expValid = 1'b1;
			end
			ACT_TO_RX: begin
				rowOk = txAck;
				expNext = ST_RX;
				expValid = 1'b1;
			end
			ACT_RX_ACK: begin
				rowOk = rxReq;
				ackVal = 1'b1;
				expNext = ST_RX;
				expValid = 1'b1;
			end
			ACT_RX_NACK_STOP: begin
				rowOk = rxReq;
				haltVal = 1'b1;
			end
			ACT_RX_NACK_STOP_START: begin
				rowOk = rxReq;
				beginVal = 1'b1;
				haltVal = 1'b1;
				expValid = 1'b1;
			end
			ACT_RX_ACK_REP: begin
				rowOk = rxReq;
				beginVal = 1'b1;
				ackVal = 1'b1;
				expValid = 1'b1;
			end
			ACT_RX_NACK_REP: begin
				rowOk = rxReq;
				beginVal = 1'b1;
				expValid = 1'b1;
			end
			ACT_RX_ACK_TX: begin
				rowOk = rxReq;
				ackVal = 1'b1;
				loadData = 1'b1;
				expNext = ST_TX;
				expValid = 1'b1;
			end
			ACT_RX_NACK_TX: begin
				rowOk = rxReq;
				loadData = 1'b1;
				expNext = ST_TX;
				expValid = 1'b1;
			end
			default: begin
				rowOk = 1'b0;
			end
		endcase
	end

endmodule

//--- smsd_host.sv
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module smsd_host
	import smsd_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// interrupt
	output logic irq,
	// controller status side
	input wire logic [3:0] statusVector,
	input wire logic arbitrationLostFlag,
	input wire logic ackReceived,
	input wire logic xferDone,
	input wire logic [BYTE_W-1:0] smbusDataRegisterRd,
	// controller response side
	output logic beginConditionRequest,
	output logic haltRequest,
	output logic ackValue,
	output logic [BYTE_W-1:0] smbusDataRegisterWr,
	output logic dataWriteStrobe,
	output logic xferDoneClear
);

	typedef enum logic [2:0] {
		S_IDLE,
		S_WAIT_CMD,
		S_LOAD,
		S_RELEASE,
		S_WAIT_CLR
	} smsd_state_type;

	localparam int SYNC_W = 1 + 4 + 1 + 1 + BYTE_W;

	smsd_state_type stateQ, stateD;
	logic [SYNC_W-1:0] syncIn;
	logic [SYNC_W-1:0] syncOut;
	logic siSync;
	logic siSyncDQ;
	logic [3:0] vecSync;
	logic arbSync;
	logic ackSync;
	logic [BYTE_W-1:0] rxSync;
	logic siNew;
	logic [3:0] vecQ;
	logic arbQ;
	logic ackQ;
	logic [BYTE_W-1:0] rxQ;
	logic [3:0] expQ;
	logic expValidQ;
	logic [ACT_W-1:0] actQ;
	logic addrOk;
	logic addrPhase;
	logic wrPendQ;
	logic [ADDR_W-1:0] wrAddrQ;
	logic cmdWrite;
	logic maskWrite;
	logic irqRead;
	logic [ACT_W-1:0] cmdAction;
	logic [BYTE_W-1:0] cmdData;
	logic pending;
	logic legal;
	logic decBegin;
	logic decHalt;
	logic decAck;
	logic decLoad;
	logic [3:0] decExp;
	logic decExpValid;
	logic cmdAccept;
	logic cmdIllegal;
	logic unexpected;
	logic [IRQ_W-1:0] irqSet;
	logic [IRQ_W-1:0] irqStatQ;
	logic [IRQ_W-1:0] irqMaskQ;
	logic [31:0] statusWord;
	logic [31:0] readMux;
	logic [31:0] hrdataQ;

	// controller signals cross into the clock domain together
	assign syncIn = {xferDone, statusVector, arbitrationLostFlag, ackReceived, smbusDataRegisterRd};
	smsd_sync #(.WIDTH(SYNC_W)) u_sync (
		.clk(clk),
		.nrst(nrst),
		.asyncIn(syncIn),
		.syncOut(syncOut)
	);
	assign {siSync, vecSync, arbSync, ackSync, rxSync} = syncOut;

	// flag seen for two cycles so status is settled when latched
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			siSyncDQ <= 1'b0;
		end else begin
			siSyncDQ <= siSync;
		end
	end
	assign siNew = stateQ == S_IDLE && siSync && siSyncDQ;

	// latch status, ack and received byte at each byte event
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			vecQ <= '0;
			arbQ <= 1'b0;
			ackQ <= 1'b0;
			rxQ <= '0;
		end else if (siNew) begin
			vecQ <= vecSync;
			arbQ <= arbSync;
			ackQ <= ackSync;
			rxQ <= rxSync;
		end
	end

	// ahb-lite address and data phase decode
	assign addrOk = haddr[31:ADDR_W] == '0;
	assign addrPhase = hsel && htrans[HTRANS_ACT_BIT] && hready;
	assign cmdWrite = wrPendQ && wrAddrQ == REG_CMD;
	assign maskWrite = wrPendQ && wrAddrQ == REG_IRQ_MASK;
	assign irqRead = addrPhase && !hwrite && addrOk && haddr[ADDR_W-1:0] == REG_IRQ_STAT;
	assign cmdAction = hwdata[CMD_ACT_LSB +: ACT_W];
	assign cmdData = hwdata[CMD_DATA_LSB +: BYTE_W];
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;
	assign hrdata = hrdataQ;

	// capture write address, register read data
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wrPendQ <= 1'b0;
			wrAddrQ <= '0;
			hrdataQ <= '0;
		end else begin
			wrPendQ <= addrPhase && hwrite && addrOk;
			wrAddrQ <= haddr[ADDR_W-1:0];
			if (addrPhase && !hwrite) begin
				hrdataQ <= readMux;
			end
		end
	end

	// status word and read selection, unmapped reads zero
	always_comb begin
		statusWord = '0;
		statusWord[STS_VEC_LSB +: 4] = vecQ;
		statusWord[STS_ARB_BIT] = arbQ;
		statusWord[STS_ACK_BIT] = ackQ;
		statusWord[STS_SI_BIT] = siSync;
		statusWord[STS_BUSY_BIT] = stateQ != S_IDLE && stateQ != S_WAIT_CMD;
		statusWord[STS_EXP_LSB +: 4] = expQ;
		statusWord[STS_EXPV_BIT] = expValidQ;
		statusWord[STS_RX_LSB +: BYTE_W] = rxQ;
	end
	assign readMux = !addrOk ? '0 :
		haddr[ADDR_W-1:0] == REG_STATUS ? statusWord :
		haddr[ADDR_W-1:0] == REG_IRQ_STAT ? {{(32-IRQ_W){1'b0}}, irqStatQ} :
		haddr[ADDR_W-1:0] == REG_IRQ_MASK ? {{(32-IRQ_W){1'b0}}, irqMaskQ} : '0;

	// response decode against the latched row
	assign pending = stateQ == S_WAIT_CMD;
	smsd_decode u_decode (
		.statusVec(vecQ),
		.arbitration_lost_flag(arbQ),
		.ackBit(ackQ),
		.pending(pending),
		.action(cmdAction),
		.legal(legal),
		.beginVal(decBegin),
		.haltVal(decHalt),
		.ackVal(decAck),
		.loadData(decLoad),
		.expNext(decExp),
		.expValid(decExpValid)
	);
	assign cmdAccept = cmdWrite && legal && (stateQ == S_IDLE || stateQ == S_WAIT_CMD);
	assign cmdIllegal = cmdWrite && !cmdAccept;
	assign unexpected = siNew && expValidQ && vecSync != expQ;

	// sequencer: data write precedes the flag clear
	always_comb begin
		stateD = stateQ;
		case (stateQ)
			S_IDLE: begin
				if (cmdAccept) begin
					stateD = S_RELEASE; // begin from idle must reach the controller
				end else if (siNew) begin
					stateD = S_WAIT_CMD;
				end
			end
			S_WAIT_CMD: begin
				if (cmdAccept) begin
					stateD = decLoad ? S_LOAD : S_RELEASE;
				end
			end
			S_LOAD: begin
				stateD = S_RELEASE;
			end
			S_RELEASE: begin
				stateD = S_WAIT_CLR;
			end
			S_WAIT_CLR: begin
				if (!siSync) begin
					stateD = S_IDLE;
				end
			end
			default: begin
				stateD = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stateQ <= S_IDLE;
		end else begin
			stateQ <= stateD;
		end
	end

	// response levels and expected next status
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			beginConditionRequest <= 1'b0;
			haltRequest <= 1'b0;
			ackValue <= 1'b0;
			smbusDataRegisterWr <= '0;
			actQ <= ACT_BEGIN;
			expQ <= ST_START;
			expValidQ <= 1'b0;
		end else if (cmdAccept) begin
			beginConditionRequest <= decBegin;
			haltRequest <= decHalt;
			ackValue <= decAck;
			actQ <= cmdAction;
			expQ <= decExp;
			expValidQ <= decExpValid;
			if (decLoad) begin
				smbusDataRegisterWr <= cmdData;
			end
		end else if (siNew) begin
			expValidQ <= 1'b0;
		end
	end

	// strobes to the controller
	assign dataWriteStrobe = stateQ == S_LOAD;
	assign xferDoneClear = stateQ == S_RELEASE;

	// sticky events, set wins over read clear
	assign irqSet[IRQ_BYTE] = siNew;
	assign irqSet[IRQ_ILLEGAL] = cmdIllegal;
	assign irqSet[IRQ_UNEXP] = unexpected;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irqStatQ <= '0;
			irqMaskQ <= IRQ_MASK_RST;
		end else begin
			irqStatQ <= (irqRead ? '0 : irqStatQ) | irqSet;
			if (maskWrite) begin
				irqMaskQ <= hwdata[IRQ_W-1:0];
			end
		end
	end
	assign irq = |(irqStatQ & irqMaskQ);

	// checks on the response presented when the flag is cleared
	chk_addr_load_levels: assert property (@(posedge clk) disable iff (!nrst)
		(xferDoneClear && actQ == ACT_LOAD_ADDR) |->
		(!beginConditionRequest && !haltRequest && $past(dataWriteStrobe) && expQ == ST_TX))
		else $error("address load must write data with begin and halt low");
	chk_nack_choice: assert property (@(posedge clk) disable iff (!nrst)
		(xferDoneClear && vecQ == ST_TX && !ackQ) |->
		(beginConditionRequest != haltRequest && !$past(dataWriteStrobe)))
		else $error("after a refused byte only restart or abort may follow");
	chk_tx_continue: assert property (@(posedge clk) disable iff (!nrst)
		(xferDoneClear && actQ == ACT_LOAD_DATA) |->
		($past(dataWriteStrobe) && expValidQ && expQ == ST_TX && !beginConditionRequest))
		else $error("next data byte must be written with expectation 1100");
	chk_stop_start: assert property (@(posedge clk) disable iff (!nrst)
		(xferDoneClear && actQ == ACT_STOP_START) |->
		(beginConditionRequest && haltRequest && !expValidQ))
		else $error("halt then begin must drive both requests high");
	chk_rx_switch: assert property (@(posedge clk) disable iff (!nrst)
		(xferDoneClear && actQ == ACT_TO_RX) |->
		(!$past(dataWriteStrobe) && expQ == ST_RX && !haltRequest))
		else $error("switch to receive must not write data");
	chk_rx_ack_cont: assert property (@(posedge clk) disable iff (!nrst)
		(xferDoneClear && actQ == ACT_RX_ACK) |->
		(ackValue && !beginConditionRequest && !haltRequest && expQ == ST_RX))
		else $error("acknowledge and continue levels wrong");
	chk_rx_halt: assert property (@(posedge clk) disable iff (!nrst)
		(xferDoneClear && actQ == ACT_RX_NACK_STOP) |->
		(!ackValue && haltRequest && !beginConditionRequest))
		else $error("final byte halt levels wrong");
	chk_rx_repeat: assert property (@(posedge clk) disable iff (!nrst)
		(xferDoneClear && (actQ == ACT_RX_ACK_REP || actQ == ACT_RX_NACK_REP)) |->
		(beginConditionRequest && !haltRequest && expQ == ST_START
		&& ackValue == (actQ == ACT_RX_ACK_REP)))
		else $error("repeated begin from receive levels wrong");
	chk_rx_to_tx: assert property (@(posedge clk) disable iff (!nrst)
		(dataWriteStrobe && (actQ == ACT_RX_ACK_TX || actQ == ACT_RX_NACK_TX)) |=>
		(xferDoneClear && !beginConditionRequest && !haltRequest && expQ == ST_TX))
		else $error("data must be written one cycle before the flag clear");
	chk_accept_release: assert property (@(posedge clk) disable iff (!nrst)
		(cmdAccept && stateQ == S_WAIT_CMD) |-> ##[1:2] xferDoneClear)
		else $error("accepted response not released within two cycles");

endmodule

//--- smsd_dev_model.sv
`timescale 1ns/1ps
module smsd_dev_model
	import smsd_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// responses from the host
	input wire logic beginReq,
	input wire logic haltReq,
	input wire logic ackVal,
	input wire logic [BYTE_W-1:0] wrByte,
	input wire logic wrStb,
	input wire logic doneClr,
	// knobs from the bench
	input wire logic slaveAck,
	input wire logic [BYTE_W-1:0] rxByte,
	input wire logic [4:0] lat,
	// status towards the host, written byte towards the bench
	output logic [3:0] statusVector,
	output logic arbitrationLostFlag,
	output logic ackReceived,
	output logic xferDone,
	output logic [BYTE_W-1:0] rdByte,
	output logic [BYTE_W-1:0] txByte
);
	logic run;
	logic wrote;
	logic [4:0] cnt;

	// byte engine: holds the bus while the flag is up, acts once it is cleared
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			run <= 1'b0;
			wrote <= 1'b0;
			cnt <= 5'h00;
			xferDone <= 1'b0;
			statusVector <= 4'h0;
			arbitrationLostFlag <= 1'b0;
			ackReceived <= 1'b0;
			rdByte <= 8'h00;
			txByte <= 8'h00;
		end else begin
			if (wrStb) begin
				txByte <= wrByte;
				wrote <= 1'b1;
			end
			if (doneClr) begin
				xferDone <= 1'b0;
				run <= 1'b1;
				cnt <= lat;
			end else if (run && cnt != 5'h00) begin
				cnt <= cnt - 5'h01;
			end else if (run) begin
				run <= 1'b0;
				wrote <= 1'b0;
				arbitrationLostFlag <= 1'b0;
				// ack level plays no part in what is sent
				if (beginReq) begin
					statusVector <= ST_START;
					xferDone <= 1'b1;
				end else if (haltReq) begin
					statusVector <= 4'h0;
				end else if (wrote || statusVector == ST_START) begin
					statusVector <= ST_TX;
					ackReceived <= slaveAck;
					xferDone <= 1'b1;
				end else begin
					statusVector <= ST_RX;
					rdByte <= rxByte;
					xferDone <= 1'b1;
				end
			end
		end
	end
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top
	import smsd_pkg::*;
;
	// bus side
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hready, hresp, irq;
	logic [31:0] hrdata;
	// controller link
	logic [3:0] stVec;
	logic arbitration_lost_flag, ackRx, xDone, begReq, haltReq, ackVal, wrStb, doneClr;
	logic [7:0] rdByte, wrByte, txByte;
	// bench state
	logic slaveAck = 1'b0;
	logic [7:0] rxByte = 8'h00;
	logic [4:0] lat = 5'h05;
	logic rdPh = 1'b0;
	logic [31:0] expQ[$];
	logic [31:0] mskQ[$];
	logic [31:0] seed = 32'h0000D0A8;
	logic [15:0] plan [31];
	int badCount = 0;
	int checksDone = 0;

	always #20 clk = ~clk;

	smsd_host dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
		.hresp(hresp), .hrdata(hrdata), .irq(irq), .statusVector(stVec),
		.arbitrationLostFlag(arbitration_lost_flag), .ackReceived(ackRx), .xferDone(xDone),
		.smbusDataRegisterRd(rdByte), .beginConditionRequest(begReq), .haltRequest(haltReq),
		.ackValue(ackVal), .smbusDataRegisterWr(wrByte), .dataWriteStrobe(wrStb),
		.xferDoneClear(doneClr));

	smsd_dev_model dev (.clk(clk), .nrst(nrst), .beginReq(begReq), .haltReq(haltReq),
		.ackVal(ackVal), .wrByte(wrByte), .wrStb(wrStb), .doneClr(doneClr),
		.slaveAck(slaveAck), .rxByte(rxByte), .lat(lat), .statusVector(stVec),
		.arbitrationLostFlag(arbitration_lost_flag), .ackReceived(ackRx), .xferDone(xDone),
		.rdByte(rdByte), .txByte(txByte));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			badCount++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmpBit(input logic got, input logic exp);
		checksDone++;
		if (got !== exp) begin
			badCount++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one single transfer; a read notes its masked expectation first
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m);
		if (!w) begin
			expQ.push_back(d & m);
			mskQ.push_back(m);
		end
		@(posedge clk);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		hsel <= 1'b1;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		rdPh <= !w;
		do @(posedge clk); while (hready !== 1'b1);
		rdPh <= 1'b0;
	endtask

	task automatic waitIrq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 400) begin
			@(posedge clk);
			#1;
			n++;
		end
		cmpBit(irq, 1'b1);
	endtask

	task automatic summarize();
		if (badCount == 0 && checksDone > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// read data is judged as each data phase completes
	always @(posedge clk) begin
		if (rdPh && hready === 1'b1 && expQ.size() > 0) begin
			cmp32(hrdata & mskQ.pop_front(), expQ.pop_front());
			cmpBit(hresp, HRESP_OKAY);
		end
	end

	// hang guard
	initial begin
		#(40 * 20000);
		badCount++;
		summarize();
	end

	// main sequence: action, expected vector (0 = none), slave ack
	initial begin
		int i;
		int n;
		logic [7:0] act, b, rx;
		logic [3:0] vec;
		logic [31:0] e, m;
		logic expAck, expHalt;
		plan = '{16'h00E0, 16'h01C1, 16'h04C1, 16'h07E0,
			16'h01C0, 16'h02E0, 16'h01C1, 16'h0881,
			16'h0980, 16'h0CE0, 16'h01C1, 16'h0880,
			16'h0DE0, 16'h01C1, 16'h0880, 16'h0EC1,
			16'h0880, 16'h0FC1, 16'h0880, 16'h0BE0,
			16'h01C1, 16'h06E0, 16'h01C0, 16'h0300,
			16'h00E0, 16'h01C1, 16'h0500, 16'h00E0,
			16'h01C1, 16'h0880, 16'h0A00};
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		ahb(1'b0, REG_IRQ_MASK, {29'h0, IRQ_MASK_RST}, 32'h7);
		ahb(1'b1, 8'h40, 32'hFFFFFFFF, 32'h0);
		ahb(1'b0, 8'h40, 32'h0, 32'hFFFFFFFF);
		ahb(1'b0, REG_IRQ_MASK, 32'h0, 32'h7);
		ahb(1'b1, REG_IRQ_MASK, 32'h7, 32'h0);
		ahb(1'b0, REG_IRQ_MASK, 32'h7, 32'h7);
		for (i = 0; i < 31; i++) begin
			act = plan[i][15:8];
			vec = plan[i][7:4];
			seed = xs(seed);
			b = seed[7:0];
			rx = seed[15:8];
			rxByte <= rx;
			slaveAck <= plan[i][0];
			lat <= 5'h05 + {1'b0, seed[19:16]};
			e = 32'h0;
			e[CMD_ACT_LSB+:ACT_W] = act[ACT_W-1:0];
			e[CMD_DATA_LSB+:BYTE_W] = b;
			ahb(1'b1, REG_CMD, e, 32'h0);
			// response levels settle at the edge that ends the command write
			expAck = act[ACT_W-1:0] inside {ACT_RX_ACK, ACT_RX_ACK_REP, ACT_RX_ACK_TX};
			expHalt = act[ACT_W-1:0] inside {ACT_ABORT, ACT_STOP, ACT_STOP_START,
				ACT_RX_NACK_STOP, ACT_RX_NACK_STOP_START};
			#1 cmpBit(ackVal, expAck);
			cmpBit(haltReq, expHalt);
			if (vec == 4'h0) begin
				n = 0;
				while (xDone !== 1'b0 && n < 100) begin
					@(posedge clk);
					n++;
				end
				repeat (SYNC_STAGES + 3) @(posedge clk);
				ahb(1'b0, REG_STATUS, 32'h0, 32'h1 << STS_BUSY_BIT);
			end else begin
				waitIrq();
				if (i == 0) begin
					ahb(1'b1, REG_IRQ_MASK, 32'h0, 32'h0);
					#1 cmpBit(irq, 1'b0);
					ahb(1'b1, REG_IRQ_MASK, 32'h7, 32'h0);
					#1 cmpBit(irq, 1'b1);
					ahb(1'b1, REG_CMD, {27'h0, ACT_RX_ACK}, 32'h0);
					ahb(1'b0, REG_IRQ_STAT, 32'h3, 32'h3);
				end else begin
					ahb(1'b0, REG_IRQ_STAT, 32'h1, 32'h1);
				end
				#1 cmpBit(irq, 1'b0);
				e = 32'h0;
				m = 32'h0;
				e[STS_VEC_LSB+:4] = vec;
				m[STS_VEC_LSB+:4] = 4'hF;
				m[STS_ARB_BIT] = 1'b1;
				if (vec == ST_TX) begin
					e[STS_ACK_BIT] = plan[i][0];
					m[STS_ACK_BIT] = 1'b1;
				end
				if (vec == ST_RX) begin
					e[STS_RX_LSB+:8] = rx;
					m[STS_RX_LSB+:8] = 8'hFF;
				end
				ahb(1'b0, REG_STATUS, e, m);
				if (act[ACT_W-1:0] inside {ACT_LOAD_ADDR, ACT_LOAD_DATA, ACT_RX_ACK_TX,
					ACT_RX_NACK_TX}) begin
					cmp32({24'h0, txByte}, {24'h0, b});
				end
			end
		end
		summarize();
	end
endmodule
